// [eep_write_path.sv]
// Two-wire EEPROM slave, write side: conditions, addressing, page buffer, programming.
// Assumes an external pull-up resolves the data line from sda_oe; reads are handled elsewhere.
`timescale 1ns/100ps
`default_nettype none

module eep_write_path #(
  parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES
) (
  // Clocks and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic scl_clk,
  // Data line, open drain
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  // Straps and protection
  input  wire logic chip_select_bit2,
  input  wire logic chip_select_bit1,
  input  wire logic chip_select_bit0,
  input  wire logic write_protect,
  // Status
  output logic      busy,
  output logic      standby,
  output logic      id_locked
);

  localparam int PCW = $clog2(PROG_CYCLES + 1);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    eep_pkg::eep_state_type st;
    eep_pkg::eep_kind_type  kind;
    logic                   spec;
    logic [2:0]             scl_q;
    logic [2:0]             sda_q;
    logic [2:0]             tg_q;
    logic [2:0]             cs_q1;
    logic [2:0]             cs_q2;
    logic [1:0]             wp_q;
    logic [3:0]             cnt;
    logic [7:0]             shreg;
    logic                   ack;
    logic [7:0]             addr_hi;
    logic [eep_pkg::PAGE_W-1:0] page;
    logic [eep_pkg::PTR_W-1:0]  ptr;
    logic [eep_pkg::PAGE_BYTES-1:0] mask;
    logic                   lock_pend;
    logic                   id_locked;
    logic                   busy;
    logic [PCW-1:0]         pcnt;
    logic                   sda_oe;
    logic                   drv_lvl;
    logic                   standby;
  } eep_core_type;

  eep_core_type r_r;
  eep_core_type r_nxt;

  logic [7:0] page_buf [eep_pkg::PAGE_BYTES];
  logic [7:0] main_mem [eep_pkg::PAGE_BYTES * eep_pkg::PAGE_COUNT];
  logic [7:0] id_mem   [eep_pkg::PAGE_BYTES];

  logic                      bit_tgl;
  logic                      bit_val;
  logic                      start_w;
  logic                      stop_w;
  logic                      fall_w;
  logic                      bit_w;
  logic                      done_w;
  logic [7:0]                byte_w;
  logic                      type_ok_w;
  logic                      cs_ok_w;
  logic                      store_w;
  logic [eep_pkg::PTR_W-1:0] cidx_w;
  logic                      commit_w;
  logic                      mem_we_w;
  logic                      id_we_w;

  // ********************************************************
  // Link domain
  // ********************************************************
  eep_bit_link u_link (
    .scl_clk (scl_clk),
    .resetn  (resetn),
    .sda_i   (sda_i),
    .bit_tgl (bit_tgl),
    .bit_val (bit_val)
  );

  // ********************************************************
  // Decode
  // ********************************************************
  // Stage 0 of each synchroniser feeds stage 1 only; edges compare stages 1 and 2
  assign start_w  = r_r.scl_q[1] & r_r.scl_q[2] & r_r.sda_q[2] & ~r_r.sda_q[1]; // [RULE1] [RULE3]
  assign stop_w   = r_r.scl_q[1] & r_r.scl_q[2] & ~r_r.sda_q[2] & r_r.sda_q[1]; // [RULE2] [RULE3]
  assign fall_w   = r_r.scl_q[2] & ~r_r.scl_q[1];
  assign bit_w    = r_r.tg_q[1] ^ r_r.tg_q[2];
  assign done_w   = bit_w & (r_r.cnt == eep_pkg::BIT_LAST);
  // Link bit is held for a whole bus period, so reading it on the toggle is safe
  assign byte_w   = {r_r.shreg[6:0], bit_val}; // [RULE5]
  assign type_ok_w = (byte_w[7:4] == eep_pkg::TYPE_MAIN) |
                     (byte_w[7:4] == eep_pkg::TYPE_SPECIAL); // [RULE6]
  // Select pins are pulled low on board when left open, so they compare as zero
  assign cs_ok_w  = (byte_w[3:1] == r_r.cs_q2); // [RULE7] [RULE26]

  // Locked identification page bytes are neither stored nor acknowledged
  assign store_w  = done_w & (r_r.st == eep_pkg::ST_DATA) &
                    ((r_r.kind == eep_pkg::KIND_MAIN) |
                     ((r_r.kind == eep_pkg::KIND_ID) & ~r_r.id_locked)); // [RULE18]

  // One buffered byte is committed per cycle at the start of the timed cycle
  assign cidx_w   = r_r.pcnt[eep_pkg::PTR_W-1:0];
  assign commit_w = r_r.busy & (r_r.pcnt < PCW'(eep_pkg::PAGE_BYTES)) & r_r.mask[cidx_w]; // [RULE16]
  assign mem_we_w = commit_w & (r_r.kind == eep_pkg::KIND_MAIN) & ~r_r.wp_q[1]; // [RULE10] [RULE25]
  assign id_we_w  = commit_w & (r_r.kind == eep_pkg::KIND_ID);

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    r_nxt         = r_r;
    r_nxt.scl_q   = {r_r.scl_q[1:0], scl_clk};
    r_nxt.sda_q   = {r_r.sda_q[1:0], sda_i};
    r_nxt.tg_q    = {r_r.tg_q[1:0], bit_tgl};
    r_nxt.cs_q1   = {chip_select_bit2, chip_select_bit1, chip_select_bit0};
    r_nxt.cs_q2   = r_r.cs_q1;
    r_nxt.wp_q    = {r_r.wp_q[0], write_protect};
    r_nxt.drv_lvl = 1'b0;

    // Bit shifting and the ninth-clock acknowledge slot
    if (bit_w && (r_r.cnt < eep_pkg::ACK_SLOT)) begin
      r_nxt.shreg = byte_w;
      r_nxt.cnt   = r_r.cnt + 4'h1;
    end
    if (fall_w && (r_r.cnt == eep_pkg::ACK_SLOT)) begin
      r_nxt.sda_oe = r_r.ack; // [RULE4] [RULE5]
      r_nxt.cnt    = eep_pkg::ACK_END;
    end else if (fall_w && (r_r.cnt == eep_pkg::ACK_END)) begin
      r_nxt.sda_oe = 1'b0;
      r_nxt.cnt    = 4'h0;
      r_nxt.ack    = 1'b0;
    end

    // Whole-byte handling
    if (done_w) begin
      r_nxt.ack = 1'b0;
      case (r_r.st)
        eep_pkg::ST_DEV: begin
          // A busy device answers no address, which is what polling relies on
          if (!r_r.busy && type_ok_w && cs_ok_w) begin // [RULE7] [RULE13] [RULE19]
            r_nxt.ack  = 1'b1;
            r_nxt.spec = (byte_w[7:4] == eep_pkg::TYPE_SPECIAL);
            // Reads, including the unique-ID page, are served by the read path
            r_nxt.st   = byte_w[0] ? eep_pkg::ST_READ : eep_pkg::ST_ADRH; // [RULE9] [RULE24]
          end else begin
            r_nxt.st   = eep_pkg::ST_SKIP; // [RULE8]
          end
        end
        eep_pkg::ST_ADRH: begin
          r_nxt.ack     = 1'b1; // [RULE11]
          r_nxt.addr_hi = byte_w;
          r_nxt.st      = eep_pkg::ST_ADRL;
        end
        eep_pkg::ST_ADRL: begin
          r_nxt.ack       = 1'b1; // [RULE11]
          r_nxt.page      = {r_r.addr_hi[3:0], byte_w[7:5]}; // [RULE12]
          r_nxt.ptr       = byte_w[4:0]; // [RULE17]
          r_nxt.mask      = '0;
          r_nxt.lock_pend = 1'b0;
          // Select bit one on the special type only ever means lock; the unique-ID page has no store
          if (!r_r.spec) begin
            r_nxt.kind = eep_pkg::KIND_MAIN;
          end else if (r_r.addr_hi[eep_pkg::SPECIAL_SEL_BIT]) begin
            r_nxt.kind = eep_pkg::KIND_LOCK; // [RULE22] [RULE23]
          end else begin
            r_nxt.kind = eep_pkg::KIND_ID; // [RULE17]
          end
          r_nxt.st = eep_pkg::ST_DATA;
        end
        eep_pkg::ST_DATA: begin
          if (r_r.kind == eep_pkg::KIND_LOCK) begin
            r_nxt.ack = 1'b1;
            if (byte_w[eep_pkg::LOCK_DATA_BIT]) begin
              r_nxt.lock_pend = 1'b1; // [RULE23]
            end
          end else if (store_w) begin
            r_nxt.ack           = 1'b1; // [RULE25]
            r_nxt.mask[r_r.ptr] = 1'b1; // [RULE16]
            r_nxt.ptr           = r_r.ptr + 5'h1; // [RULE14] [RULE15]
          end
        end
        default: begin
        end
      endcase
    end

    // Timed programming cycle
    if (r_r.busy) begin
      r_nxt.pcnt = r_r.pcnt + PCW'(1);
      if (r_r.pcnt == PCW'(PROG_CYCLES - 1)) begin
        r_nxt.busy    = 1'b0;
        r_nxt.pcnt    = '0;
        r_nxt.standby = 1'b1; // [RULE20]
        if (r_r.kind == eep_pkg::KIND_LOCK) begin
          r_nxt.id_locked = 1'b1; // [RULE23]
        end
      end
    end

    // Bus conditions override the byte engine; any start resynchronises a hung bus
    if (start_w) begin
      r_nxt.st      = eep_pkg::ST_DEV; // [RULE1] [RULE21]
      r_nxt.cnt     = 4'h0;
      r_nxt.sda_oe  = 1'b0;
      r_nxt.ack     = 1'b0;
      r_nxt.standby = 1'b0;
    end else if (stop_w) begin
      r_nxt.st     = eep_pkg::ST_IDLE; // [RULE2]
      r_nxt.cnt    = 4'h0;
      r_nxt.sda_oe = 1'b0;
      r_nxt.ack    = 1'b0;
      if ((r_r.st == eep_pkg::ST_DATA) && !r_r.busy &&
          ((r_r.mask != '0) ||
           ((r_r.kind == eep_pkg::KIND_LOCK) && r_r.lock_pend))) begin
        r_nxt.busy = 1'b1; // [RULE13]
        r_nxt.pcnt = '0;
      end else if (!r_r.busy) begin
        r_nxt.standby = 1'b1; // [RULE20]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_r         <= '0;
      r_r.scl_q   <= 3'h7;
      r_r.sda_q   <= 3'h7;
      r_r.standby <= 1'b1; // [RULE20]
    end else begin
      r_r <= r_nxt;
    end
  end

  // ********************************************************
  // Storage
  // ********************************************************
  // No reset on the arrays: contents survive like the nonvolatile cells
  always_ff @(posedge clk_sys) begin
    if (store_w) begin
      page_buf[r_r.ptr] <= byte_w; // [RULE15]
    end
    if (mem_we_w) begin
      main_mem[{r_r.page, cidx_w}] <= page_buf[cidx_w]; // [RULE12]
    end
    if (id_we_w) begin
      id_mem[cidx_w] <= page_buf[cidx_w]; // [RULE17]
    end
  end

  assign sda_o     = r_r.drv_lvl;
  assign sda_oe    = r_r.sda_oe;
  assign busy      = r_r.busy;
  assign standby   = r_r.standby;
  assign id_locked = r_r.id_locked;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  start_taken_a: assert property (start_w |=> r_r.st == eep_pkg::ST_DEV) // [RULE1]
    else $error("start condition not taken");

  stop_ends_a: assert property (stop_w |=> r_r.st == eep_pkg::ST_IDLE && !r_r.sda_oe) // [RULE2]
    else $error("stop did not end the transaction");

  ack_slot_a: assert property ($rose(r_r.sda_oe) |-> $past(r_r.cnt) == eep_pkg::ACK_SLOT
                                && r_r.cnt == eep_pkg::ACK_END) // [RULE5]
    else $error("acknowledge driven outside the ninth clock");

  addr_miss_a: assert property (done_w && !start_w && !stop_w && r_r.st == eep_pkg::ST_DEV
                                && !(type_ok_w && cs_ok_w)
                                |=> r_r.st == eep_pkg::ST_SKIP && !r_r.ack) // [RULE8]
    else $error("mismatched address was accepted");

  busy_nack_a: assert property (r_r.busy && done_w && r_r.st == eep_pkg::ST_DEV
                                |=> !r_r.ack) // [RULE19]
    else $error("address acknowledged while programming");

  page_wrap_a: assert property (store_w && !start_w && !stop_w
                                |=> r_r.ptr == $past(r_r.ptr) + 5'h1) // [RULE14]
    else $error("page pointer did not advance");

  lock_nack_a: assert property (done_w && r_r.st == eep_pkg::ST_DATA && r_r.id_locked
                                && r_r.kind == eep_pkg::KIND_ID |=> !r_r.ack) // [RULE18]
    else $error("locked page data acknowledged");

  wp_guard_a: assert property (r_r.wp_q[1] && r_r.kind == eep_pkg::KIND_MAIN
                               |-> !mem_we_w) // [RULE10]
    else $error("protected array written");

  prog_hold_a: assert property ($rose(r_r.busy) |-> r_r.busy [*8]) // [RULE13]
    else $error("programming cycle ended early");

  standby_a: assert property ($fell(r_r.busy) && !$past(start_w) |-> r_r.standby) // [RULE20]
    else $error("no standby after programming");

  // The pull-down may only stand inside the ninth clock of a word
  ack_window_a: assert property (r_r.sda_oe |-> r_r.cnt == eep_pkg::ACK_END) // [RULE5]
    else $error("data line held low outside the acknowledge clock");

  bit_count_a: assert property (r_r.cnt <= eep_pkg::ACK_END) // [RULE5]
    else $error("bit counter ran past the acknowledge clock");

  // The full timed cycle must run before the device answers again
  prog_length_a: assert property ($fell(r_r.busy)
                                  |-> $past(r_r.pcnt) == PCW'(PROG_CYCLES - 1)) // [RULE13]
    else $error("programming cycle length wrong");

  busy_awake_a: assert property (r_r.busy |-> !r_r.standby) // [RULE20]
    else $error("standby shown while programming");

  // Once locked, nothing may reach the identification page cells
  id_frozen_a: assert property (r_r.id_locked |-> !id_we_w) // [RULE18]
    else $error("locked identification page written");

endmodule // eep_write_path
`default_nettype wire

// [eep_pkg.sv]
// Constants and shared types for the two-wire EEPROM write path.
// Assumes the bus clock, data and strap pins arrive from outside the system clock domain.
//
// Functional notes
// RULE1: Data falling while clock high is a start; recognised at any time.
// RULE2: Data rising while clock high is a stop; it ends the transaction.
// RULE3: Data changes only while clock low; a change with clock high is a bus condition.
// RULE4: Bits are sampled on clock rise; acknowledge is driven after clock fall.
// RULE5: Words are 8 bits, MSB first; accepted words are acknowledged low on the ninth clock.
// RULE6: The first word after start is type 1010, three select bits, direction bit.
// RULE7: Acknowledge only when type is valid and all three select bits match the pins.
// RULE8: A mismatched address gets no acknowledge; the bus is ignored until next start.
// RULE9: Address LSB one starts a read, zero starts a write.
// RULE10: Write protect high blocks every write to the main array.
// RULE11: Byte write is address word, high then low address byte, one data byte, stop.
// RULE12: Main array is 128 pages of 32 bytes, 12-bit byte address.
// RULE13: Stop after write data starts a 3 ms programming cycle with no acknowledge.
// RULE14: Page write increments only the low five address bits, wrapping inside the page.
// RULE15: More than 32 data bytes overwrite the earlier bytes of the same page.
// RULE16: A partial page write is accepted; only bytes received are programmed.
// RULE17: Identification page write uses type 1011 and select bit zero; low five bits index.
// RULE18: A locked identification page withholds acknowledge for data and is not programmed.
// RULE19: Polling with start and address is acknowledged only after programming ends.
// RULE20: Standby at power-up and after stop once internal work is complete.
// RULE21: The master recovers a hung bus by clocking up to nine times, then a start.
// RULE22: The 8-byte unique-ID page is read-only; writes never change it.
// RULE23: Lock command is a byte write, type 1011, select bit one, data bit 1 set.
// RULE24: The unique-ID page is read like a random read with type 1011, select bit one.
// RULE25: Protected main array writes are still acknowledged but never programmed.
// RULE26: An unconnected select pin counts as logic low.

package eep_pkg;

  // ********************************************************
  // Protocol fields
  // ********************************************************
  localparam logic [3:0] TYPE_MAIN       = 4'ha;
  localparam logic [3:0] TYPE_SPECIAL    = 4'hb;
  localparam logic [3:0] BIT_LAST        = 4'h7;
  localparam logic [3:0] ACK_SLOT        = 4'h8;
  localparam logic [3:0] ACK_END         = 4'h9;
  localparam int         SPECIAL_SEL_BIT = 2;   // Bit 10 of the address, bit 2 of the high byte
  localparam int         LOCK_DATA_BIT   = 1;

  // ********************************************************
  // Array geometry
  // ********************************************************
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_COUNT = 128;
  localparam int PTR_W      = 5;
  localparam int PAGE_W     = 7;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int PROG_TIME_MS = 3;
  localparam int CLK_MHZ      = 200;
  localparam int PROG_CYCLES  = PROG_TIME_MS * CLK_MHZ * 1000;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEV  = 3'h1,
    ST_ADRH = 3'h3,
    ST_ADRL = 3'h2,
    ST_DATA = 3'h6,
    ST_SKIP = 3'h7,
    ST_READ = 3'h4
  } eep_state_type;

  typedef enum logic [1:0] {
    KIND_MAIN = 2'h0,
    KIND_ID   = 2'h1,
    KIND_LOCK = 2'h2
  } eep_kind_type;

endpackage

// [eep_bit_link.sv]
// Link-side bit capture, clocked by the bus clock itself.
// Assumes the data line is stable around each rising bus clock edge.
`timescale 1ns/100ps
`default_nettype none

module eep_bit_link (
  // Link clock and reset
  input  wire logic scl_clk,
  input  wire logic resetn,
  // Data line level
  input  wire logic sda_i,
  // Toggle per sampled bit, with the bit held until the next edge
  output logic      bit_tgl,
  output logic      bit_val
);

  typedef struct packed {
    logic tgl;
    logic val;
  } eep_link_type;

  eep_link_type r_r;
  eep_link_type r_nxt;

  // The bus clock stops between frames, so each edge just flips the toggle
  always_comb begin
    r_nxt     = r_r;
    r_nxt.tgl = ~r_r.tgl;
    r_nxt.val = sda_i;  // [RULE4]
  end

  always_ff @(posedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign bit_tgl = r_r.tgl;
  assign bit_val = r_r.val;

endmodule // eep_bit_link
`default_nettype wire

// [eep_master.sv]
// Two-wire bus master model: drives the bus clock and pulls the data line low.
// Assumes a pull-up on the data line and the system clock for pacing.
`timescale 1ns/100ps
`default_nettype none

module eep_master #(
  parameter int QTR = 6
) (
  // Pacing clock
  input  wire logic clk_sys,
  // Bus
  input  wire logic sda_i,
  output logic      scl_clk,
  output logic      sda_pull
);
  initial begin
    scl_clk  = 1'b1;
    sda_pull = 1'b0;
  end

  // Each phase lasts several system cycles so the synchronisers see every level
  task automatic gap();
    repeat (QTR) @(negedge clk_sys);
  endtask

  // One clock pulse from low; the level is taken late in the high phase
  task automatic pulse(output logic lvl);
    gap();
    scl_clk = 1'b1;
    gap();
    lvl = sda_i;
    scl_clk = 1'b0;
    gap();
  endtask

  task automatic start();
    sda_pull = 1'b0;
    scl_clk  = 1'b1;
    gap();
    sda_pull = 1'b1;
    gap();
    scl_clk = 1'b0;
    gap();
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    gap();
    scl_clk = 1'b1;
    gap();
    sda_pull = 1'b0;
    gap();
  endtask

  // One word MSB first; ack is high when the ninth clock saw the line low
  task automatic send(input logic [7:0] b, output logic ack);
    logic lvl;
    for (int i = 7; i >= 0; i--) begin
      sda_pull = ~b[i];
      pulse(lvl);
    end
    sda_pull = 1'b0;
    pulse(lvl);
    ack = (lvl === 1'b0);
  endtask

  // Clocks until the line is seen high, nine pulses at most, then a start and a stop
  task automatic recover();
    logic lvl;
    scl_clk = 1'b0;
    for (int i = 0; i < 9; i++) begin
      pulse(lvl);
      if (lvl === 1'b1) break;
    end
    start();
    stop();
  endtask
endmodule // eep_master

`default_nettype wire

// [eep_write_path_bench.sv]
// Self-checking bench for the write path, with a bus master model on the link.
// Assumes memories main_mem and id_mem are reachable by hierarchy.
`timescale 1ns/100ps
`default_nettype none

module eep_write_path_bench;
  localparam int PROG = 400;
  typedef struct packed {
    logic [2:0] cs;
    logic [7:0] dev;
    logic       ack;
  } eep_row_type;

  logic        clk_sys;
  logic        resetn;
  logic        scl_clk;
  logic        sda_pull;
  logic        sda_i;
  logic        sda_o;
  logic        sda_oe;
  logic [2:0]  cs;
  logic        wp;
  logic        busy;
  logic        standby;
  logic        id_locked;
  logic        a;
  int          err_total;
  int          n_compared;
  logic [7:0]  q[$];
  eep_row_type rows[6];

  // ********************************************************
  // Clock, bus and instances
  // ********************************************************
  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;
  assign sda_i = ~(sda_pull | (sda_oe & ~sda_o));

  eep_master m (.clk_sys(clk_sys), .sda_i(sda_i), .scl_clk(scl_clk), .sda_pull(sda_pull));

  eep_write_path #(.PROG_CYCLES(PROG)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .scl_clk(scl_clk), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_bit2(cs[2]),
    .chip_select_bit1(cs[1]), .chip_select_bit0(cs[0]), .write_protect(wp),
    .busy(busy), .standby(standby), .id_locked(id_locked));

  // ********************************************************
  // Checking and closing
  // ********************************************************
  task automatic print_verdict();
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Programming may be long; a bounded wait keeps a stuck busy from hanging the run
  task automatic wait_idle();
    int n;
    repeat (10) @(negedge clk_sys);
    for (n = 0; n < 2000 && !(busy === 1'b0 && standby === 1'b1); n++) @(negedge clk_sys);
    if (n == 2000) begin
      err_total++;
      $display("wrong value at %0t: device never returned to standby", $time);
      print_verdict();
    end
  endtask

  // Whole transaction; every word but the last must be acknowledged
  task automatic wr(input logic [7:0] w[$], output logic last);
    logic k;
    m.start();
    foreach (w[i]) begin
      m.send(w[i], k);
      if (i < w.size() - 1) chk({7'h0, k}, 8'h01);
    end
    last = k;
    m.stop();
  endtask

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    resetn = 1'b0;
    cs = 3'h0;
    wp = 1'b0;
    err_total = 0;
    n_compared = 0;
    rows = '{'{3'h5, 8'haa, 1'b1}, '{3'h5, 8'ha8, 1'b0}, '{3'h0, 8'ha0, 1'b1},
             '{3'h0, 8'he0, 1'b0}, '{3'h7, 8'haf, 1'b1}, '{3'h2, 8'ha2, 1'b0}};
    repeat (20) @(negedge clk_sys);
    chk({3'h0, sda_o, sda_oe, busy, standby, id_locked}, 8'h02);
    resetn = 1'b1;
    repeat (10) @(negedge clk_sys);
    m.recover();
    wait_idle();
    foreach (rows[i]) begin
      cs = rows[i].cs;
      repeat (4) @(negedge clk_sys);
      m.start();
      m.send(rows[i].dev, a);
      chk({7'h0, a}, {7'h0, rows[i].ack});
      if (!rows[i].ack) begin
        m.send({4'ha, rows[i].cs, 1'b0}, a);
        chk({7'h0, a}, 8'h00);
      end
      m.stop();
      wait_idle();
    end
    cs = 3'h0;
    // Byte write with the top address bits set, then polling while busy
    wr('{8'ha0, 8'hf1, 8'h23, 8'h5a}, a);
    chk({7'h0, a}, 8'h01);
    repeat (10) @(negedge clk_sys);
    chk({6'h0, busy, standby}, 8'h02);
    m.start();
    m.send(8'ha0, a);
    chk({7'h0, a}, 8'h00);
    m.stop();
    wait_idle();
    chk(dut.main_mem[12'h123], 8'h5a);
    m.start();
    m.send(8'ha0, a);
    chk({7'h0, a}, 8'h01);
    m.stop();
    wait_idle();
    // Page write of 34 bytes from index 30 wraps once over the page start
    q = '{8'ha0, 8'h00, 8'h5e};
    for (int k = 0; k < 34; k++) q.push_back(8'h80 + 8'(k));
    wr(q, a);
    chk({7'h0, a}, 8'h01);
    wait_idle();
    chk(dut.main_mem[12'h05e], 8'ha0);
    chk(dut.main_mem[12'h05f], 8'ha1);
    chk(dut.main_mem[12'h040], 8'h82);
    chk(dut.main_mem[12'h05d], 8'h9f);
    // Protected array: acknowledged but unchanged
    wp = 1'b1;
    repeat (4) @(negedge clk_sys);
    wr('{8'ha0, 8'h01, 8'h23, 8'ha5}, a);
    chk({7'h0, a}, 8'h01);
    wait_idle();
    chk(dut.main_mem[12'h123], 8'h5a);
    wp = 1'b0;
    // Identification page write, lock, then refused write
    wr('{8'hb0, 8'hf8, 8'h03, 8'h77}, a);
    wait_idle();
    chk(dut.id_mem[3], 8'h77);
    wr('{8'hb0, 8'h04, 8'h00, 8'h01}, a);
    wait_idle();
    chk({7'h0, id_locked}, 8'h00);
    wr('{8'hb0, 8'h04, 8'h00, 8'h02}, a);
    wait_idle();
    chk({7'h0, id_locked}, 8'h01);
    wr('{8'hb0, 8'h00, 8'h03, 8'h11}, a);
    chk({7'h0, a}, 8'h00);
    wait_idle();
    chk(dut.id_mem[3], 8'h77);
    print_verdict();
  end
endmodule // eep_write_path_bench

`default_nettype wire
